/* File: integer_alu_imm_and_three_op.sv */
`timescale 1ns/1ps
/*
 Integer execution datapath for the immediate operations and the 32-bit
 three-register operations of a 64-bit core.
 It holds the operand extension, the adders and the subtractor, the compares,
 the bitwise group, the operation decode, the overflow detection and a one-stage
 result register.
 Operation codes handled, by their package names:
   OP_LESS_THAN_IMM_UNSIGNED: unsigned compare with the sign-extended immediate.
   OP_BITWISE_CONJ_IMM: AND with the zero-extended immediate.
   OP_BITWISE_DISJ_IMM: OR with the zero-extended immediate.
   OP_BITWISE_EXCLUSIVE_IMM: XOR with the zero-extended immediate.
   OP_UPPER_HALF_IMM_LOAD: immediate placed in bits 31:16 of the word.
   OP_WIDE_SUM_IMM_TRAPPING: 64-bit add of the sign-extended immediate, traps.
   OP_WIDE_SUM_IMM_WRAPPING: the same 64-bit add, never traps.
   OP_WORD_SUM_TRAPPING: 32-bit add of the two sources, traps.
   OP_WORD_SUM_WRAPPING: 32-bit add of the two sources, never traps.
   OP_WORD_DIFF_TRAPPING: 32-bit first minus second, traps.
   OP_WORD_DIFFERENCE_WRAPPING: 32-bit first minus second, never traps.
   OP_LESS_THAN_SIGNED: signed compare of the two sources.
   OP_LESS_THAN_UNSIGNED: unsigned compare of the two sources.
   OP_LOGIC_CONJ: bitwise AND of the two sources.
   OP_LOGIC_DISJ: bitwise OR of the two sources.
   OP_LOGIC_EXCLUSIVE: bitwise XOR of the two sources.
   OP_LOGIC_NEITHER: bitwise NOR of the two sources.
 Any other code writes nothing and raises nothing.
 Assumes the decoder supplies the source values already read from the register
 file, one operation per cycle marked by issue_valid, with the immediate, both
 indices and mode_64 in the same cycle.
 Assumes the register file takes wb_data at wb_index while wb_enable is high and
 the exception unit takes overflow_trap; both strobes stand for one cycle, one
 clock after the issuing edge.
 Immediate forms write to second_gpr_index and three-register forms to dest_index.
 Word operations read only bits 31:0 of each source; in 32-bit mode a word result
 is written with its upper half cleared.
*/
// Behaviour
// - Unsigned compare against the sign-extended immediate writes 1 if below, else 0.
// - Immediate AND zero-extends the immediate and ANDs it with the source.
// - Immediate OR zero-extends the immediate and ORs it with the source.
// - Immediate XOR zero-extends the immediate and XORs it with the source.
// - Upper immediate load sets bits 31:16, clears 15:0, sign-extends in 64-bit mode.
// - Trapping wide immediate add forms a 64-bit sum and traps on signed overflow.
// - Wrapping wide immediate add forms the same 64-bit sum and never traps.
// - Trapping word add forms a 32-bit sum and traps on signed overflow.
// - Wrapping word add forms a 32-bit sum and never traps.
// - Trapping word subtract forms first minus second and traps on signed overflow.
// - Wrapping word subtract forms first minus second and never traps.
// - Signed compare writes 1 when the first source is smaller, else 0.
// - Unsigned compare writes 1 when the first source is smaller, else 0.
// - The register logical group applies AND, OR, XOR or NOR bit by bit.
module integer_alu_imm_and_three_op (
    input  wire logic        sys_clk,           // Core clock, 250 MHz.
    input  wire logic        rst,               // Synchronous reset, active high.
    input  wire logic        issue_valid,       // Operation presented this cycle.
    input  wire logic [4:0]  op_code,           // Operation select.
    input  wire logic        mode_64,           // 64-bit operating mode.
    input  wire logic [63:0] first_src_val,     // Value of the first source register.
    input  wire logic [63:0] second_src_val,    // Value of the second source register.
    input  wire logic [15:0] imm_field,         // Immediate field.
    input  wire logic [4:0]  second_gpr_index,  // Second register index (immediate target).
    input  wire logic [4:0]  dest_index,        // Destination index of register forms.
    output logic      [63:0] wb_data,           // Result for the register file.
    output logic      [4:0]  wb_index,          // Register index written.
    output logic             wb_enable,         // One-cycle register write strobe.
    output logic             overflow_trap      // One-cycle integer overflow trap.
);
    // Word results are widened by copying bit 31 in 64-bit mode and by zeros otherwise.
    function automatic logic [63:0] word_ext(input logic [31:0] w, input logic m64);
        word_ext = m64 ? {{32{w[31]}}, w} : {32'h0, w};
    endfunction : word_ext

    // Signed overflow: both addends share a sign and the sum shows the other one.
    function automatic logic add_ovf(input logic sa, input logic sb, input logic sr);
        add_ovf = (sa == sb) && (sr != sa);
    endfunction : add_ovf

    // Immediate extensions and the low words of both sources.
    wire logic [63:0] imm_sext = {{48{imm_field[15]}}, imm_field};
    wire logic [63:0] imm_zext = {48'h0, imm_field};
    wire logic [31:0] a_w      = first_src_val[31:0];
    wire logic [31:0] b_w      = second_src_val[31:0];

    wire logic [63:0] wide_sum = first_src_val + imm_sext;
    wire logic [31:0] w_sum    = a_w + b_w;
    wire logic [31:0] w_diff   = a_w - b_w;
    wire logic [31:0] upr_word = {imm_field, 16'h0};

    // A subtraction overflows as an addition of the inverted second operand would.
    wire logic wide_ovf = add_ovf(first_src_val[63], imm_sext[63], wide_sum[63]);
    wire logic sum_ovf  = add_ovf(a_w[31], b_w[31], w_sum[31]);
    wire logic diff_ovf = add_ovf(a_w[31], ~b_w[31], w_diff[31]);

    // Compares use the full 64-bit sources; the immediate compare is unsigned.
    wire logic lt_imm_u = first_src_val < imm_sext;
    wire logic lt_s     = $signed(first_src_val) < $signed(second_src_val);
    wire logic lt_u     = first_src_val < second_src_val;

    // One named line per operation code; the write strobes read this decode.
    wire logic lt_imm_u_op  = op_code == alu_pkg::OP_LESS_THAN_IMM_UNSIGNED;
    wire logic conj_imm_op  = op_code == alu_pkg::OP_BITWISE_CONJ_IMM;
    wire logic disj_imm_op  = op_code == alu_pkg::OP_BITWISE_DISJ_IMM;
    wire logic excl_imm_op  = op_code == alu_pkg::OP_BITWISE_EXCLUSIVE_IMM;
    wire logic upper_op     = op_code == alu_pkg::OP_UPPER_HALF_IMM_LOAD;
    wire logic wide_trap_op = op_code == alu_pkg::OP_WIDE_SUM_IMM_TRAPPING;
    wire logic wide_wrap_op = op_code == alu_pkg::OP_WIDE_SUM_IMM_WRAPPING;
    wire logic sum_trap_op  = op_code == alu_pkg::OP_WORD_SUM_TRAPPING;
    wire logic sum_wrap_op  = op_code == alu_pkg::OP_WORD_SUM_WRAPPING;
    wire logic diff_trap_op = op_code == alu_pkg::OP_WORD_DIFF_TRAPPING;
    wire logic diff_wrap_op = op_code == alu_pkg::OP_WORD_DIFFERENCE_WRAPPING;
    wire logic lt_s_op      = op_code == alu_pkg::OP_LESS_THAN_SIGNED;
    wire logic lt_u_op      = op_code == alu_pkg::OP_LESS_THAN_UNSIGNED;
    wire logic conj_op      = op_code == alu_pkg::OP_LOGIC_CONJ;
    wire logic disj_op      = op_code == alu_pkg::OP_LOGIC_DISJ;
    wire logic excl_op      = op_code == alu_pkg::OP_LOGIC_EXCLUSIVE;
    wire logic neither_op   = op_code == alu_pkg::OP_LOGIC_NEITHER;

    // Only the three trapping forms may ever raise the trap, whatever ovf says.
    wire logic trap_form = wide_trap_op | sum_trap_op | diff_trap_op;
    wire logic imm_form  = lt_imm_u_op | conj_imm_op | disj_imm_op | excl_imm_op
                         | upper_op | wide_trap_op | wide_wrap_op;
    wire logic reg_form  = sum_trap_op | sum_wrap_op | diff_trap_op | diff_wrap_op
                         | lt_s_op | lt_u_op | conj_op | disj_op | excl_op | neither_op;

    // The case below selects result and target; only trapping arms set ovf.
    logic [63:0] res;
    logic [4:0]  idx;
    logic        ovf;

    always_comb begin
        res   = 64'h0;
        idx   = dest_index;
        ovf   = 1'b0;
        case (op_code)
            alu_pkg::OP_LESS_THAN_IMM_UNSIGNED: begin
                res = {63'h0, lt_imm_u};
                idx = second_gpr_index;
            end
            alu_pkg::OP_BITWISE_CONJ_IMM: begin
                res = first_src_val & imm_zext;
                idx = second_gpr_index;
            end
            alu_pkg::OP_BITWISE_DISJ_IMM: begin
                res = first_src_val | imm_zext;
                idx = second_gpr_index;
            end
            alu_pkg::OP_BITWISE_EXCLUSIVE_IMM: begin
                res = first_src_val ^ imm_zext;
                idx = second_gpr_index;
            end
            alu_pkg::OP_UPPER_HALF_IMM_LOAD: begin
                res = word_ext(upr_word, mode_64);
                idx = second_gpr_index;
            end
            alu_pkg::OP_WIDE_SUM_IMM_TRAPPING: begin
                res = wide_sum;
                ovf = wide_ovf;
                idx = second_gpr_index;
            end
            alu_pkg::OP_WIDE_SUM_IMM_WRAPPING: begin
                res = wide_sum;
                idx = second_gpr_index;
            end
            alu_pkg::OP_WORD_SUM_TRAPPING: begin
                res = word_ext(w_sum, mode_64);
                ovf = sum_ovf;
            end
            alu_pkg::OP_WORD_SUM_WRAPPING: begin
                res = word_ext(w_sum, mode_64);
            end
            alu_pkg::OP_WORD_DIFF_TRAPPING: begin
                res = word_ext(w_diff, mode_64);
                ovf = diff_ovf;
            end
            alu_pkg::OP_WORD_DIFFERENCE_WRAPPING: begin
                res = word_ext(w_diff, mode_64);
            end
            alu_pkg::OP_LESS_THAN_SIGNED: begin
                res = {63'h0, lt_s};
            end
            alu_pkg::OP_LESS_THAN_UNSIGNED: begin
                res = {63'h0, lt_u};
            end
            alu_pkg::OP_LOGIC_CONJ: begin
                res = first_src_val & second_src_val;
            end
            alu_pkg::OP_LOGIC_DISJ: begin
                res = first_src_val | second_src_val;
            end
            alu_pkg::OP_LOGIC_EXCLUSIVE: begin
                res = first_src_val ^ second_src_val;
            end
            alu_pkg::OP_LOGIC_NEITHER: begin
                res = ~(first_src_val | second_src_val);
            end
            default: begin
                res = 64'h0;
            end
        endcase
    end

    // An unknown code writes nothing and raises nothing.
    wire logic fire_d = issue_valid && (imm_form || reg_form);
    wire logic trap_d = fire_d && trap_form && ovf;
    wire logic wen_d  = fire_d && !ovf;

    // The result stage registers every output, so both strobes are clean pulses.
    alu_result_reg u_result (
        .sys_clk (sys_clk),
        .rst     (rst),
        .res_d   (res),
        .idx_d   (idx),
        .wen_d   (wen_d),
        .trap_d  (trap_d),
        .res_q   (wb_data),
        .idx_q   (wb_index),
        .wen_q   (wb_enable),
        .trap_q  (overflow_trap)
    );
endmodule : integer_alu_imm_and_three_op

/* File: alu_pkg.sv */
/*
 Shared constants for the integer execution datapath: operation codes and field widths.
 Assumes the decoder presents one operation code per issued instruction.
*/
package alu_pkg;
    localparam int XLEN      = 64;
    localparam int WLEN      = 32;
    localparam int IMM_W     = 16;
    localparam int IDX_W     = 5;
    localparam int OP_W      = 5;
    localparam int UPPER_SHIFT = 16;
    localparam logic [4:0] OP_LESS_THAN_IMM_UNSIGNED = 5'h00;
    localparam logic [4:0] OP_BITWISE_CONJ_IMM       = 5'h01;
    localparam logic [4:0] OP_BITWISE_DISJ_IMM       = 5'h02;
    localparam logic [4:0] OP_BITWISE_EXCLUSIVE_IMM  = 5'h03;
    localparam logic [4:0] OP_UPPER_HALF_IMM_LOAD    = 5'h04;
    localparam logic [4:0] OP_WIDE_SUM_IMM_TRAPPING  = 5'h05;
    localparam logic [4:0] OP_WIDE_SUM_IMM_WRAPPING  = 5'h06;
    localparam logic [4:0] OP_WORD_SUM_TRAPPING      = 5'h07;
    localparam logic [4:0] OP_WORD_SUM_WRAPPING      = 5'h08;
    localparam logic [4:0] OP_WORD_DIFF_TRAPPING     = 5'h09;
    localparam logic [4:0] OP_WORD_DIFFERENCE_WRAPPING = 5'h0A;
    localparam logic [4:0] OP_LESS_THAN_SIGNED       = 5'h0B;
    localparam logic [4:0] OP_LESS_THAN_UNSIGNED     = 5'h0C;
    localparam logic [4:0] OP_LOGIC_CONJ             = 5'h0D;
    localparam logic [4:0] OP_LOGIC_DISJ             = 5'h0E;
    localparam logic [4:0] OP_LOGIC_EXCLUSIVE        = 5'h0F;
    localparam logic [4:0] OP_LOGIC_NEITHER          = 5'h10;
endpackage : alu_pkg

/* File: alu_result_reg.sv */
`timescale 1ns/1ps
/*
 Result stage register: holds the write-back value, index, enable and trap pulse.
 Assumes the same clock and synchronous active-high reset as the datapath.
*/
module alu_result_reg (
    input  wire logic        sys_clk,       // Core clock.
    input  wire logic        rst,           // Synchronous reset.
    input  wire logic [63:0] res_d,         // Next result value.
    input  wire logic [4:0]  idx_d,         // Next destination index.
    input  wire logic        wen_d,         // Next write enable.
    input  wire logic        trap_d,        // Next overflow trap.
    output logic      [63:0] res_q,         // Registered result.
    output logic      [4:0]  idx_q,         // Registered destination index.
    output logic             wen_q,         // Registered write enable.
    output logic             trap_q         // Registered overflow trap.
);
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            res_q  <= 64'h0;
            idx_q  <= 5'h0;
            wen_q  <= 1'b0;
            trap_q <= 1'b0;
        end else begin
            res_q  <= res_d;
            idx_q  <= idx_d;
            wen_q  <= wen_d;
            trap_q <= trap_d;
        end
    end
endmodule : alu_result_reg

/* File: gpr_model.sv */
`timescale 1ns/1ps
/* Register file and exception unit stand-in: takes writes and counts traps.
 Assumes it watches the datapath outputs on the core clock. */
module gpr_model (
    input  wire logic        sys_clk,       // Core clock.
    input  wire logic [63:0] wb_data,       // Write data.
    input  wire logic [4:0]  wb_index,      // Write index.
    input  wire logic        wb_enable,     // Write strobe.
    input  wire logic        overflow_trap, // Trap pulse.
    output int               traps = 0,     // Traps taken.
    output int               writes = 0     // Register writes taken.
);
    logic [63:0] gpr [32];
    always @(posedge sys_clk) begin
        if (wb_enable) gpr[wb_index] <= wb_data;
        if (overflow_trap) traps <= traps + 1;
        if (wb_enable) writes <= writes + 1;
    end
endmodule : gpr_model

/* File: alu_monitor.sv */
`timescale 1ns/1ps
/* Port checks on the integer datapath, result one cycle after issue.
 Assumes the bind below attaches it to the datapath. */
module alu_monitor (
    input wire logic        sys_clk,        // Clock.
    input wire logic        rst,            // Reset.
    input wire logic        issue_valid,    // Issue.
    input wire logic [4:0]  op_code,        // Operation.
    input wire logic        mode_64,        // Mode.
    input wire logic [63:0] first_src_val,  // Source one.
    input wire logic [63:0] second_src_val, // Source two.
    input wire logic [15:0] imm_field,      // Immediate.
    input wire logic [63:0] wb_data,        // Result.
    input wire logic        wb_enable,      // Write.
    input wire logic        overflow_trap   // Trap.
);
    logic [63:0] a_q, b_q;
    logic [15:0] i_q;
    logic        m_q;
    wire  logic [31:0] dw = first_src_val[31:0] - second_src_val[31:0];
    wire  logic [31:0] sw = a_q[31:0] + b_q[31:0];
    wire  logic [63:0] ws = first_src_val + {{48{imm_field[15]}}, imm_field};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    always_ff @(posedge sys_clk) begin
        a_q <= first_src_val;
        b_q <= second_src_val;
        i_q <= imm_field;
        m_q <= mode_64;
    end
    property p_lt_imm; issue_valid && op_code == alu_pkg::OP_LESS_THAN_IMM_UNSIGNED
        |=> wb_data == {63'h0, a_q < {{48{i_q[15]}}, i_q}}; endproperty
    a_lt_imm: assert property (p_lt_imm) else $error("imm compare wrong");
    property p_xor_imm; issue_valid && op_code == alu_pkg::OP_BITWISE_EXCLUSIVE_IMM
        |=> wb_enable && wb_data == (a_q ^ {48'h0, i_q}); endproperty
    a_xor_imm: assert property (p_xor_imm) else $error("imm xor wrong");
    property p_upper; issue_valid && op_code == alu_pkg::OP_UPPER_HALF_IMM_LOAD
        |=> wb_data == {{32{m_q & i_q[15]}}, i_q, 16'h0}; endproperty
    a_upper: assert property (p_upper) else $error("upper load wrong");
    property p_wide; issue_valid && op_code == alu_pkg::OP_WIDE_SUM_IMM_WRAPPING
        |=> !overflow_trap && wb_data == a_q + {{48{i_q[15]}}, i_q}; endproperty
    a_wide: assert property (p_wide) else $error("wide add wrong");
    property p_sum; issue_valid && op_code == alu_pkg::OP_WORD_SUM_WRAPPING |=> wb_enable
        && wb_data == {{32{m_q & sw[31]}}, sw}; endproperty
    a_sum: assert property (p_sum) else $error("word add wrong");
    property p_diff; issue_valid && op_code == alu_pkg::OP_WORD_DIFF_TRAPPING
        && first_src_val[31] != second_src_val[31] && dw[31] != first_src_val[31]
        |=> overflow_trap && !wb_enable; endproperty
    a_diff: assert property (p_diff) else $error("sub trap wrong");
    property p_wide_trap; issue_valid && op_code == alu_pkg::OP_WIDE_SUM_IMM_TRAPPING
        && first_src_val[63] == imm_field[15] && ws[63] != first_src_val[63]
        |=> overflow_trap && !wb_enable; endproperty
    a_wide_trap: assert property (p_wide_trap) else $error("wide trap wrong");
    property p_slt; issue_valid && op_code == alu_pkg::OP_LESS_THAN_SIGNED
        |=> wb_data == {63'h0, $signed(a_q) < $signed(b_q)}; endproperty
    a_slt: assert property (p_slt) else $error("signed compare wrong");
    property p_nor; issue_valid && op_code == alu_pkg::OP_LOGIC_NEITHER
        |=> wb_data == ~(a_q | b_q); endproperty
    a_nor: assert property (p_nor) else $error("nor wrong");
endmodule : alu_monitor
bind integer_alu_imm_and_three_op alu_monitor u_mon (.sys_clk, .rst, .issue_valid,
    .op_code, .mode_64, .first_src_val, .second_src_val, .imm_field, .wb_data,
    .wb_enable, .overflow_trap);

/* File: test_integer_alu_imm_and_three_op.sv */
`timescale 1ns/1ps
/* Bench for the integer datapath: trap corners, then random back-to-back ops.
 Assumes the monitor is bound and gpr_model watches the outputs. */
module test_integer_alu_imm_and_three_op;
    logic sys_clk = 0, rst = 1, issue_valid = 0, mode_64 = 0, wb_enable, overflow_trap;
    logic [4:0] op_code = 0, second_gpr_index = 0, dest_index = 0, wb_index;
    logic [63:0] first_src_val = 0, second_src_val = 0, wb_data;
    logic [15:0] imm_field = 0;
    logic [70:0] exp_q[$], e;
    int n_errors = 0, compares = 0, seed = 95360, n_traps = 0, traps, n_writes = 0, writes;
    integer_alu_imm_and_three_op dut (.sys_clk, .rst, .issue_valid, .op_code, .mode_64,
        .first_src_val, .second_src_val, .imm_field, .second_gpr_index, .dest_index,
        .wb_data, .wb_index, .wb_enable, .overflow_trap);
    gpr_model u_gpr (.sys_clk, .wb_data, .wb_index, .wb_enable, .overflow_trap, .traps,
        .writes);
    initial forever #2 sys_clk = ~sys_clk;
    function automatic logic [63:0] sx(input logic [31:0] v, input logic m);
        return {m ? {32{v[31]}} : 32'h0, v};
    endfunction : sx
    function automatic logic [65:0] exp_of(input logic [4:0] o, input logic [63:0] a, b,
                                           input logic [15:0] i, input logic m);
        logic [63:0] se, w;
        logic [31:0] s, d;
        se = {{48{i[15]}}, i};
        w = a + se;
        s = a[31:0] + b[31:0];
        d = a[31:0] - b[31:0];
        case (o)
            5'h00: return {2'h2, 63'h0, a < se};
            5'h01: return {2'h2, a & {48'h0, i}};
            5'h02: return {2'h2, a | {48'h0, i}};
            5'h03: return {2'h2, a ^ {48'h0, i}};
            5'h04: return {2'h2, sx({i, 16'h0}, m)};
            5'h05: return {a[63] == se[63] && w[63] != a[63] ? 2'h1 : 2'h2, w};
            5'h06: return {2'h2, w};
            5'h07: return {a[31] == b[31] && s[31] != a[31] ? 2'h1 : 2'h2, sx(s, m)};
            5'h08: return {2'h2, sx(s, m)};
            5'h09: return {a[31] != b[31] && d[31] != a[31] ? 2'h1 : 2'h2, sx(d, m)};
            5'h0A: return {2'h2, sx(d, m)};
            5'h0B: return {2'h2, 63'h0, $signed(a) < $signed(b)};
            5'h0C: return {2'h2, 63'h0, a < b};
            5'h0D: return {2'h2, a & b};
            5'h0E: return {2'h2, a | b};
            5'h0F: return {2'h2, a ^ b};
            5'h10: return {2'h2, ~(a | b)};
            default: return 66'h0;
        endcase
    endfunction : exp_of
    task automatic check(input string what, input logic [63:0] x, s);
        compares++;
        if (s !== x) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, x, s);
        end
    endtask : check
    task automatic issue(input logic [4:0] o, input logic [63:0] a, b, input logic [15:0] i);
        logic [65:0] r;
        @(negedge sys_clk);
        {issue_valid, op_code, first_src_val, second_src_val, imm_field} = {1'h1, o, a, b, i};
        {mode_64, second_gpr_index, dest_index} = 11'($random(seed));
        r = exp_of(o, a, b, i, mode_64);
        if (r[65:64] != 2'h0)
            exp_q.push_back({r[65:64], o < 5'h07 ? second_gpr_index : dest_index, r[63:0]});
        n_traps += r[64];
        n_writes += r[65];
    endtask : issue
    task automatic close_out;
        $display("counts compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out
    always @(negedge sys_clk) if (!rst && (wb_enable || overflow_trap)) begin
        e = exp_q.size() > 0 ? exp_q.pop_front() : 71'h0;
        check("strobes", e[70:69], {wb_enable, overflow_trap});
        if (e[70]) check("index", e[68:64], wb_index);
        if (e[70]) check("data", e[63:0], wb_data);
    end
    initial begin
        #20000;
        n_errors++;
        close_out();
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk) rst = 0;
        issue(5'h07, 64'h7FFFFFFF, 64'h1, 16'h0);
        issue(5'h09, 64'h80000000, 64'h1, 16'h0);
        issue(5'h05, 64'h7FFFFFFFFFFFFFFF, 64'h0, 16'h1);
        issue(5'h06, 64'h7FFFFFFFFFFFFFFF, 64'h0, 16'h1);
        $display("test corners done");
        repeat (800) if ($random(seed) % 4 == 0) @(negedge sys_clk) issue_valid = 0;
        else issue(5'($unsigned($random(seed)) % 18), {$random(seed), $random(seed)},
                   {$random(seed), $random(seed)}, 16'($random(seed)));
        @(negedge sys_clk) issue_valid = 0;
        repeat (3) @(negedge sys_clk);
        check("pending", 64'h0, exp_q.size());
        check("traps", n_traps, traps);
        check("writes", n_writes, writes);
        $display("test random done");
        close_out();
    end
endmodule : test_integer_alu_imm_and_three_op
